//--- verilog/cmgr_cfg.svh
`ifndef CMGR_CFG_SVH
`define CMGR_CFG_SVH

// register offsets on the control port
`define CMGR_ADDR_MIX_PAIR1      8'h18
`define CMGR_ADDR_MIX_PAIR2      8'h19
`define CMGR_ADDR_MIX_PAIR3      8'h1A
`define CMGR_ADDR_ADC_LEFT_GAIN  8'h1C
`define CMGR_ADDR_ADC_RIGHT_GAIN 8'h1D
`define CMGR_ADDR_RX_MODE        8'h1E
`define CMGR_ADDR_RX_MODE_TWO    8'h1F
`define CMGR_ADDR_IRQ_FLAGS      8'h20

// writable bits per register; for the flags, the bits that events can set
`define CMGR_MASK_MIX            8'h1F
`define CMGR_MASK_GAIN           8'h3F
`define CMGR_MASK_RX_MODE        8'hBF
`define CMGR_MASK_RX_MODE_TWO    8'h77
`define CMGR_MASK_FLAGS          8'hBB

// reset values
`define CMGR_RST_MIX             5'h09
`define CMGR_RST_GAIN            6'h00
`define CMGR_RST_RX_MODE         8'h00
`define CMGR_RST_RX_MODE_TWO     8'h00

// field positions
`define CMGR_MIX_CROSS_BIT       4
`define CMGR_PHASE_ALIGN_BIT     7
`define CMGR_DEEMPH_LSB          4
`define CMGR_IRQ_POL_LSB         2
`define CMGR_HOLD_LSB            0
`define CMGR_PASSTHRU_LSB        4
`define CMGR_RXSEL_LSB           0

// special mixing codes that average B-left with A-right
`define CMGR_MIX_A_SWAP          5'h1E
`define CMGR_MIX_B_SWAP          5'h17

// transition timing, in sample periods
`define CMGR_ZC_TIMEOUT          512
`define CMGR_RAMP_PERIODS        8

`endif

//--- verilog/cmgr_pkg.sv
package cmgr_pkg;

    typedef enum logic [1:0] {
        CMGR_TR_IMMEDIATE = 2'h0,
        CMGR_TR_ZERO_CROSS = 2'h1,
        CMGR_TR_SOFT_RAMP = 2'h2,
        CMGR_TR_RAMP_ZC = 2'h3
    } cmgr_trans_type;

    typedef enum logic [1:0] {
        CMGR_IRQ_HIGH = 2'h0,
        CMGR_IRQ_LOW = 2'h1,
        CMGR_IRQ_OPEN_DRAIN = 2'h2,
        CMGR_IRQ_RSVD = 2'h3
    } cmgr_irq_pol_type;

    typedef enum logic [1:0] {
        CMGR_HOLD_LAST = 2'h0,
        CMGR_HOLD_ZERO = 2'h1,
        CMGR_HOLD_PASS = 2'h2,
        CMGR_HOLD_RSVD = 2'h3
    } cmgr_hold_type;

    typedef logic signed [5:0] cmgr_gain_type;

endpackage

//--- verilog/cmgr_gain_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cmgr_gain_if;
    import cmgr_pkg::*;
    cmgr_gain_type target;
    cmgr_gain_type applied;
    logic          zero_cross;

    modport ctrl (output target, output zero_cross, input applied);
    modport step (input target, input zero_cross, output applied);
endinterface

`default_nettype wire

//--- verilog/cmgr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// depth must be a power of two so the pointers wrap on their own
module cmgr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign out_valid = (count != '0);
    assign out_data  = mem[rptr];

    always_comb begin
        push       = in_valid & in_ready;
        pop        = out_valid & out_ready;
        next_wptr  = push ? wptr + 1'b1 : wptr;
        next_rptr  = pop ? rptr + 1'b1 : rptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wptr     <= '0;
            rptr     <= '0;
            count    <= '0;
            in_ready <= 1'b0;
        end else begin
            wptr     <= next_wptr;
            rptr     <= next_rptr;
            count    <= next_count;
            in_ready <= (next_count != FULL_COUNT);
        end
    end

    // storage has no reset, it is only read behind count
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
endmodule // cmgr_fifo

`default_nettype wire

//--- verilog/cmgr_gain_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmgr_cfg.svh"

module cmgr_gain_step
    import cmgr_pkg::*;
#(
    parameter int TIMEOUT = `CMGR_ZC_TIMEOUT,
    parameter int RAMP    = `CMGR_RAMP_PERIODS
) (
    // clock and reset
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    // transition control
    input  wire logic [1:0] transition_mode,
    input  wire logic     sample_tick,
    // channel
    cmgr_gain_if.step     chan
);
    localparam int TW = $clog2(TIMEOUT) + 1;
    localparam int RW = $clog2(RAMP) + 1;
    localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT - 1);
    localparam logic [RW-1:0] RAMP_LAST = RW'(RAMP - 1);

    cmgr_trans_type mode;
    cmgr_gain_type  applied;
    cmgr_gain_type  next_applied;
    cmgr_gain_type  one_step;
    logic [TW-1:0]  timer;
    logic [TW-1:0]  next_timer;
    logic [RW-1:0]  ramp_cnt;
    logic [RW-1:0]  next_ramp_cnt;
    logic           zc_event;

    assign chan.applied = applied;

    always_comb begin
        mode          = cmgr_trans_type'(transition_mode);
        one_step      = (chan.target > applied) ? applied + 6'sd1 : applied - 6'sd1;
        // a crossing or the sample timeout, whichever comes first
        zc_event      = chan.zero_cross | (sample_tick && timer == TIMEOUT_LAST);
        next_applied  = applied;
        next_timer    = timer;
        next_ramp_cnt = ramp_cnt;
        if (chan.target == applied) begin
            next_timer    = '0;
            next_ramp_cnt = '0;
        end else begin
            unique case (mode)
                CMGR_TR_IMMEDIATE: begin
                    next_applied = chan.target;
                end
                CMGR_TR_ZERO_CROSS: begin
                    if (zc_event) begin
                        next_applied = chan.target;
                        next_timer   = '0;
                    end else if (sample_tick) begin
                        next_timer = timer + 1'b1;
                    end
                end
                CMGR_TR_SOFT_RAMP: begin
                    if (sample_tick) begin
                        next_ramp_cnt = (ramp_cnt == RAMP_LAST) ? '0 : ramp_cnt + 1'b1;
                        if (ramp_cnt == RAMP_LAST) begin
                            next_applied = one_step;
                        end
                    end
                end
                CMGR_TR_RAMP_ZC: begin
                    if (zc_event) begin
                        next_applied = one_step;
                        next_timer   = '0;
                    end else if (sample_tick) begin
                        next_timer = timer + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            applied  <= `CMGR_RST_GAIN;
            timer    <= '0;
            ramp_cnt <= '0;
        end else begin
            applied  <= next_applied;
            timer    <= next_timer;
            ramp_cnt <= next_ramp_cnt;
        end
    end
endmodule // cmgr_gain_step

`default_nettype wire

//--- verilog/cmgr_top.sv
// Notes on behaviour
// - five-bit mix code per pair, resets 01001
// - selectors: mute, right, left, half sum
// - cross mode averages A-left and B-right, two exceptions
// - six-bit signed ADC gains, reset zero
// - gain changes follow selected transition mode
// - zero cross or 512-period timeout, per channel
// - phase-align bit syncs both serial ports
// - de-emphasis code used only under forced lock
// - interrupt pin polarity and drive style
// - receiver error sample policy: hold, zero, pass
// - three-bit select drives pass-through output
// - separate three-bit select feeds the receiver
// - status bit set if event since last read
// - reading status clears all bits afterwards, except bits set by an event in the read cycle
// - masked status bits always read zero
// - mask gates status setting and interrupt pin
// - bit 7 on clock-recovery unlock
// - bit 5 on changed subcode block
// - bit 4 on channel-status buffer update
// - bit 0 on any receiver error
// - bit 1 on ADC over-range
`timescale 1ns/1ps
`default_nettype none
`include "cmgr_cfg.svh"

module cmgr_top
    import cmgr_pkg::*;
#(
    parameter int SAMPLE_W   = 24,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // control port
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_wdata,
    output logic [7:0]                  reg_rdata,
    output logic                        reg_rvalid,
    // dac mixing stream, per pair: a-left, a-right, b-left, b-right
    input  wire logic                   frame_valid,
    output logic                        frame_ready,
    input  wire logic [12*SAMPLE_W-1:0] frame_data,
    output logic                        mix_valid,
    input  wire logic                   mix_ready,
    output logic [6*SAMPLE_W-1:0]       mix_data,
    // adc gain transitions
    input  wire logic [1:0]             transition_mode,
    input  wire logic                   sample_tick,
    input  wire logic [1:0]             adc_zero_cross,
    output logic [5:0]                  left_input_gain,
    output logic [5:0]                  right_input_gain,
    // receiver
    input  wire logic                   forced_lock,
    input  wire logic [7:0]             rx_input,
    output logic                        passthru_output,
    output logic                        receiver_feed,
    input  wire logic                   rx_sample_valid,
    input  wire logic                   rx_sample_error,
    input  wire logic [SAMPLE_W-1:0]    rx_sample,
    output logic                        rx_audio_valid,
    output logic [SAMPLE_W-1:0]         rx_audio,
    output logic                        port_phase_align,
    output logic [1:0]                  deemph_active,
    // interrupt sources and pin
    input  wire logic [7:0]             irq_event,
    input  wire logic [7:0]             irq_mask,
    output logic                        irq_out,
    output logic                        irq_oe_n
);
    localparam int W = SAMPLE_W;

    // register state
    logic [4:0]             pair_mix_code [3];
    logic [4:0]             next_pair_mix_code [3];
    logic [5:0]             gain_reg [2];
    logic [5:0]             next_gain_reg [2];
    logic [7:0]             rx_mode;
    logic [7:0]             next_rx_mode;
    logic [7:0]             rx_mode_two;
    logic [7:0]             next_rx_mode_two;
    logic [7:0]             flags;
    logic [7:0]             next_flags;
    logic [7:0]             next_rdata;
    logic                   status_read;

    // output state
    logic                   next_irq_out;
    logic                   next_irq_oe_n;
    logic                   irq_pending;
    cmgr_irq_pol_type       irq_polarity;
    logic [1:0]             next_deemph;
    logic [W-1:0]           last_valid;
    logic [W-1:0]           next_last_valid;
    logic [W-1:0]           next_rx_audio;
    cmgr_hold_type          error_sample_policy;

    // mixing path
    logic                   fifo_valid;
    logic                   fifo_take;
    logic [12*W-1:0]        fifo_data;
    logic [6*W-1:0]         next_mix_data;
    logic                   next_mix_valid;

    // registers
    always_comb begin
        next_pair_mix_code = pair_mix_code;
        next_gain_reg      = gain_reg;
        next_rx_mode       = rx_mode;
        next_rx_mode_two   = rx_mode_two;
        if (reg_wr) begin
            unique case (reg_addr)
                `CMGR_ADDR_MIX_PAIR1: next_pair_mix_code[0] = reg_wdata[4:0];
                `CMGR_ADDR_MIX_PAIR2: next_pair_mix_code[1] = reg_wdata[4:0];
                `CMGR_ADDR_MIX_PAIR3: next_pair_mix_code[2] = reg_wdata[4:0];
                `CMGR_ADDR_ADC_LEFT_GAIN: next_gain_reg[0] = reg_wdata[5:0];
                `CMGR_ADDR_ADC_RIGHT_GAIN: next_gain_reg[1] = reg_wdata[5:0];
                `CMGR_ADDR_RX_MODE: next_rx_mode = reg_wdata & `CMGR_MASK_RX_MODE;
                `CMGR_ADDR_RX_MODE_TWO: next_rx_mode_two = reg_wdata & `CMGR_MASK_RX_MODE_TWO;
                default: ;
            endcase
        end
    end

    // status flags: a new event wins over the read clear
    always_comb begin
        status_read = reg_rd && (reg_addr == `CMGR_ADDR_IRQ_FLAGS);
        next_flags  = status_read ? 8'h00 : flags;
        // bits 7,5,4,3,1,0 only, each gated by its mask
        next_flags  = next_flags | (irq_event & irq_mask & `CMGR_MASK_FLAGS);
    end

    // read data, unmapped and reserved bits read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `CMGR_ADDR_MIX_PAIR1: next_rdata = {3'h0, pair_mix_code[0]};
            `CMGR_ADDR_MIX_PAIR2: next_rdata = {3'h0, pair_mix_code[1]};
            `CMGR_ADDR_MIX_PAIR3: next_rdata = {3'h0, pair_mix_code[2]};
            `CMGR_ADDR_ADC_LEFT_GAIN: next_rdata = {2'h0, gain_reg[0]};
            `CMGR_ADDR_ADC_RIGHT_GAIN: next_rdata = {2'h0, gain_reg[1]};
            `CMGR_ADDR_RX_MODE: next_rdata = rx_mode;
            `CMGR_ADDR_RX_MODE_TWO: next_rdata = rx_mode_two;
            `CMGR_ADDR_IRQ_FLAGS: next_rdata = flags & irq_mask;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                pair_mix_code[i] <= `CMGR_RST_MIX;
            end
            gain_reg[0] <= `CMGR_RST_GAIN;
            gain_reg[1] <= `CMGR_RST_GAIN;
            rx_mode     <= `CMGR_RST_RX_MODE;
            rx_mode_two <= `CMGR_RST_RX_MODE_TWO;
            flags       <= 8'h00;
            reg_rdata   <= 8'h00;
            reg_rvalid  <= 1'b0;
        end else begin
            pair_mix_code <= next_pair_mix_code;
            gain_reg      <= next_gain_reg;
            rx_mode       <= next_rx_mode;
            rx_mode_two   <= next_rx_mode_two;
            flags         <= next_flags;
            reg_rdata     <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid    <= reg_rd;
        end
    end

    // adc gain channels
    cmgr_gain_if gain_ch [2] ();

    for (genvar c = 0; c < 2; c++) begin : g_gain
        assign gain_ch[c].target     = cmgr_gain_type'(gain_reg[c]);
        assign gain_ch[c].zero_cross = adc_zero_cross[c];
        cmgr_gain_step u_step (
            .clk_sys         (clk_sys),
            .rst_n           (rst_n),
            .transition_mode (transition_mode),
            .sample_tick     (sample_tick),
            .chan            (gain_ch[c])
        );
    end

    // applied gains are flip-flops inside the step modules
    assign left_input_gain  = gain_ch[0].applied;
    assign right_input_gain = gain_ch[1].applied;

    // receiver mode and pin outputs
    always_comb begin
        irq_polarity        = cmgr_irq_pol_type'(rx_mode[`CMGR_IRQ_POL_LSB +: 2]);
        error_sample_policy = cmgr_hold_type'(rx_mode[`CMGR_HOLD_LSB +: 2]);
        // reserved code 00 passes through unchanged, and 00 is also driven whenever forced_lock is low
        next_deemph  = forced_lock ? rx_mode[`CMGR_DEEMPH_LSB +: 2] : 2'h0;
        irq_pending  = |(next_flags & irq_mask);
        next_irq_out  = irq_pending;
        next_irq_oe_n = 1'b0;
        unique case (irq_polarity)
            CMGR_IRQ_HIGH: next_irq_out = irq_pending;
            CMGR_IRQ_LOW: next_irq_out = ~irq_pending;
            CMGR_IRQ_OPEN_DRAIN: begin
                next_irq_out  = 1'b0;
                next_irq_oe_n = ~irq_pending;
            end
            // reserved: released so nothing fights the line
            CMGR_IRQ_RSVD: begin
                next_irq_out  = 1'b0;
                next_irq_oe_n = 1'b1;
            end
        endcase
    end

    // received samples on error
    always_comb begin
        next_last_valid = last_valid;
        next_rx_audio   = rx_audio;
        if (rx_sample_valid) begin
            if (!rx_sample_error) begin
                next_rx_audio   = rx_sample;
                next_last_valid = rx_sample;
            end else begin
                unique case (error_sample_policy)
                    CMGR_HOLD_LAST: next_rx_audio = last_valid;
                    CMGR_HOLD_ZERO: next_rx_audio = '0;
                    CMGR_HOLD_PASS: next_rx_audio = rx_sample;
                    CMGR_HOLD_RSVD: next_rx_audio = last_valid;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_out          <= 1'b0;
            irq_oe_n         <= 1'b0;
            deemph_active    <= 2'h0;
            port_phase_align <= 1'b0;
            passthru_output  <= 1'b0;
            receiver_feed    <= 1'b0;
            last_valid       <= '0;
            rx_audio         <= '0;
            rx_audio_valid   <= 1'b0;
        end else begin
            irq_out          <= next_irq_out;
            irq_oe_n         <= next_irq_oe_n;
            deemph_active    <= next_deemph;
            port_phase_align <= rx_mode[`CMGR_PHASE_ALIGN_BIT];
            passthru_output  <= rx_input[rx_mode_two[`CMGR_PASSTHRU_LSB +: 3]];
            receiver_feed    <= rx_input[rx_mode_two[`CMGR_RXSEL_LSB +: 3]];
            last_valid       <= next_last_valid;
            rx_audio         <= next_rx_audio;
            rx_audio_valid   <= rx_sample_valid;
        end
    end

    // frames queue here so a stalled consumer pushes back on the source
    cmgr_fifo #(
        .WIDTH (12*W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (frame_valid),
        .in_ready  (frame_ready),
        .in_data   (frame_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_data)
    );

    assign fifo_take = ~mix_valid | mix_ready;

    function automatic logic [W-1:0] avg(input logic [W-1:0] x, input logic [W-1:0] y);
        logic [W:0] sum;
        sum = {x[W-1], x} + {y[W-1], y};
        return sum[W:1];
    endfunction

    function automatic logic [W-1:0] pick(input logic [1:0] sel, input logic [W-1:0] l,
                                          input logic [W-1:0] r, input logic [W-1:0] both);
        logic [W-1:0] res;
        res = '0;
        unique case (sel)
            2'h0: res = '0;
            2'h1: res = r;
            2'h2: res = l;
            2'h3: res = both;
        endcase
        return res;
    endfunction

    for (genvar p = 0; p < 3; p++) begin : g_pair
        logic [W-1:0] a_l;
        logic [W-1:0] a_r;
        logic [W-1:0] b_l;
        logic [W-1:0] b_r;
        logic [W-1:0] avg_a;
        logic [W-1:0] avg_b;
        logic [4:0]   code;
        assign a_l  = fifo_data[p*4*W +: W];
        assign a_r  = fifo_data[p*4*W+W +: W];
        assign b_l  = fifo_data[p*4*W+2*W +: W];
        assign b_r  = fifo_data[p*4*W+3*W +: W];
        assign code = pair_mix_code[p];
        always_comb begin
            avg_a = avg(a_l, a_r);
            avg_b = avg(b_l, b_r);
            if (code[`CMGR_MIX_CROSS_BIT]) begin
                avg_a = (code == `CMGR_MIX_A_SWAP) ? avg(b_l, a_r) : avg(a_l, b_r);
                avg_b = (code == `CMGR_MIX_B_SWAP) ? avg(b_l, a_r) : avg(a_l, b_r);
            end
            next_mix_data[p*2*W +: W]   = pick(code[3:2], a_l, a_r, avg_a);
            next_mix_data[p*2*W+W +: W] = pick(code[1:0], b_l, b_r, avg_b);
        end
    end

    assign next_mix_valid = fifo_valid | (mix_valid & ~mix_ready);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mix_valid <= 1'b0;
            mix_data  <= '0;
        end else begin
            mix_valid <= next_mix_valid;
            mix_data  <= (fifo_take && fifo_valid) ? next_mix_data : mix_data;
        end
    end
endmodule // cmgr_top

`default_nettype wire

//--- bench/cmgr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cmgr_top_sva (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // control port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    // status and receiver
    input wire logic [7:0] irq_event,
    input wire logic [7:0] irq_mask,
    input wire logic       forced_lock,
    input wire logic [1:0] deemph_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    AST_FLAG_RSVD: assert property (reg_rd && reg_addr == 8'h20 |=> (reg_rdata & 8'h44) == 8'h00)
        else $error("reserved flag set");
    AST_GAIN_RSVD: assert property (reg_rd && reg_addr[7:1] == 7'h0E |=> reg_rdata[7:6] == 2'h0)
        else $error("gain reserved bits set");
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h1B |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_MASKED: assert property (reg_rd && reg_addr == 8'h20 |=> (reg_rdata & ~$past(irq_mask)) == 8'h00)
        else $error("masked flag reads one");
    AST_DEEMPH: assert property (!forced_lock |=> deemph_active == 2'h0)
        else $error("deemphasis active without lock");
    // quiet events around two reads: the second must find nothing left
    AST_CLEAR: assert property (reg_rd && reg_addr == 8'h20 && irq_event == 8'h00 ##1
        irq_event == 8'h00 [*2] ##1 reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00)
        else $error("flags not cleared by read");
    COV_FLAGS: cover property (reg_rd && reg_addr == 8'h20 ##1 reg_rdata != 8'h00);
    COV_LOCK: cover property (forced_lock ##1 deemph_active != 2'h0);
    COV_GAIN: cover property (reg_rd && reg_addr == 8'h1C);
endmodule // cmgr_top_sva
bind cmgr_top cmgr_top_sva u_sva (.*);
`default_nettype wire

//--- bench/cmgr_host.sv
`timescale 1ns/1ps
`default_nettype none
module cmgr_host (
    // clock and answer
    input  wire logic       clk_sys,
    input  wire logic       reg_rvalid,
    input  wire logic [7:0] reg_rdata,
    // requests
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // strobe lasts one edge; answer taken at the edge that sees reg_rvalid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [8:0] d);
        @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(posedge clk_sys) d = {reg_rvalid, reg_rdata};
    endtask
endmodule // cmgr_host
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, frame_valid, frame_ready, mix_valid, mix_ready, sample_tick;
    logic forced_lock, passthru_output, receiver_feed, rx_sample_valid, rx_sample_error, rx_audio_valid;
    logic port_phase_align, irq_out, irq_oe_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_input, irq_event, irq_mask;
    logic [8:0] v;
    logic [1:0] transition_mode, adc_zero_cross, deemph_active;
    logic [5:0] left_input_gain, right_input_gain;
    logic [287:0] frame_data;
    logic [143:0] mix_data;
    logic [23:0] rx_sample, rx_audio;
    logic [7:0] ta[6] = '{8'h18, 8'h1B, 8'h1C, 8'h1D, 8'h1F, 8'h20};
    logic [7:0] tr[6] = '{8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] tw[6] = '{8'h1F, 8'h00, 8'h3F, 8'h3F, 8'h77, 8'h00};
    logic [7:0] mc[6] = '{8'h0F, 8'h1F, 8'h1E, 8'h17, 8'h1B, 8'h00};
    logic [47:0] me[6] = '{48'h000010000028, 48'h00002E00002E, 48'h00002800000A, 48'h00000AFFFFEC, 48'h00002E000064, 48'h0};
    int error_cnt, total_checks, n;
    cmgr_top #(.SAMPLE_W(24), .FIFO_DEPTH(4)) DUT (.*);
    cmgr_host u_host (.*);
    task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp) $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        error_cnt += (seen !== exp);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, v);
        chk("reg", v, {1'b1, e});
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic mixone;
        @(posedge clk_sys) frame_valid <= 1'b1;
        @(posedge clk_sys) frame_valid <= 1'b0;
        for (n = 0; n < 20 && mix_valid !== 1'b1; n++) @(posedge clk_sys) #1;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #100us;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rst_n, frame_valid, sample_tick, forced_lock, rx_sample_valid, rx_sample_error, mix_ready} = '0;
        {rx_input, irq_event, irq_mask, transition_mode, adc_zero_cross, rx_sample} = '0;
        frame_data = {3{24'hFFFFF9, 24'h000028, 24'hFFFFEC, 24'h000064}};
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (ta[i]) begin
            rdchk(ta[i], tr[i]);
            u_host.wr(ta[i], 8'hFF);
            rdchk(ta[i], tw[i]);
        end
        chk("gain", {left_input_gain, right_input_gain}, 12'hFFF);
        u_host.wr(8'h1E, 8'hA6);
        forced_lock <= 1'b1;
        rdchk(8'h1E, 8'hA6);
        chk("mode", {port_phase_align, deemph_active}, 3'h6);
        @(posedge clk_sys) {irq_mask, irq_event} <= {8'hB7, 8'hFF};
        @(posedge clk_sys) irq_event <= 8'h00;
        @(posedge clk_sys) #1 chk("pin", {irq_out, irq_oe_n}, 2'h0);
        rdchk(8'h20, 8'hB3);
        rdchk(8'h20, 8'h00);
        chk("pin", {irq_out, irq_oe_n}, 2'h2);
        // consumer stalls: the output register holds one frame beyond the fifo
        @(posedge clk_sys) frame_valid <= 1'b1;
        n = 0;
        repeat (8) @(posedge clk_sys) n += (frame_ready === 1'b1);
        frame_valid <= 1'b0;
        chk("fill", n, 5);
        mix_ready <= 1'b1;
        n = 0;
        repeat (8) @(posedge clk_sys) n += (mix_valid === 1'b1);
        chk("drain", n, 5);
        foreach (mc[i]) begin
            u_host.wr(8'h18, mc[i]);
            mixone();
            chk("mix", mix_data[95:0], {48'hFFFFF9000064, me[i]});
        end
        @(posedge clk_sys) transition_mode <= 2'h1;
        u_host.wr(8'h1C, 8'h05);
        repeat (1023) @(posedge clk_sys) sample_tick <= ~sample_tick;
        #1 chk("gain wait", left_input_gain, 6'h3F);
        repeat (2) @(posedge clk_sys) sample_tick <= ~sample_tick;
        #1 chk("gain timeout", left_input_gain, 6'h05);
        // tick now stays high: one step every 8 cycles
        @(posedge clk_sys) transition_mode <= 2'h2;
        u_host.wr(8'h1D, 8'h01);
        repeat (15) @(posedge clk_sys);
        #1 chk("ramp", right_input_gain, 6'h00);
        u_host.wr(8'h1E, 8'hA8);
        u_host.wr(8'h1F, 8'h16);
        @(posedge clk_sys) {rx_input, rx_sample_valid, rx_sample} <= {8'h02, 1'b1, 24'h000123};
        @(posedge clk_sys) {rx_sample_error, rx_sample} <= {1'b1, 24'h000456};
        @(posedge clk_sys) #1;
        chk("mux", {passthru_output, receiver_feed, irq_out, irq_oe_n}, 4'h9);
        chk("hold", {rx_audio_valid, rx_audio}, {1'b1, 24'h000123});
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
